/* harvard_core_alu_datapath_tb.sv */
// Self-checking bench for the Harvard core datapath
`timescale 1ns/100ps
module harvard_core_alu_datapath_tb;
  import hcad_pkg::*;
  logic               sys_clk_i = 1'b0;
  logic               nrst_i    = 1'b0;
  logic [PC_W-1:0]    pmem_addr;
  logic [INSTR_W-1:0] pmem_data;
  logic [FADDR_W-1:0] dmem_addr;
  logic [DATA_W-1:0]  dmem_rdata;
  logic [DATA_W-1:0]  dmem_wdata;
  logic               dmem_we;
  logic [DATA_W-1:0]  w_o;
  logic [DATA_W-1:0]  status_o;
  logic               icyc_o;
  int                 n_errors    = 0;
  int                 comparisons = 0;

  //////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 sys_clk_i = ~sys_clk_i;

  hcad_core dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .pmem_addr_o(pmem_addr), .pmem_data_i(pmem_data),
    .dmem_addr_o(dmem_addr), .dmem_rdata_i(dmem_rdata),
    .dmem_wdata_o(dmem_wdata), .dmem_we_o(dmem_we),
    .w_o(w_o), .status_o(status_o), .icyc_o(icyc_o));

  hcad_mem_model mem_u (.sys_clk_i(sys_clk_i), .pmem_addr_i(pmem_addr),
    .pmem_data_o(pmem_data), .dmem_addr_i(dmem_addr),
    .dmem_rdata_o(dmem_rdata), .dmem_wdata_i(dmem_wdata),
    .dmem_we_i(dmem_we));

  //////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the end of the run or from a spent wait
  task complete_run;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // Reset is applied and released on falling edges
  task do_reset;
    @(negedge sys_clk_i);
    nrst_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk({8'h00, w_o}, 16'h0000);
    chk({8'h00, status_o}, 16'h0000);
    chk({3'b000, pmem_addr}, 16'h0000);
    chk({15'h0000, dmem_we}, 16'h0000);
    nrst_i = 1'b1;
  endtask : do_reset

  // One instruction cycle: wait for its pulse, then let updates land
  task step_check(input logic [7:0] ew, input logic [7:0] es,
                  input int en);
    int n;
    n = 0;
    while (icyc_o !== 1'b1 && n < 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
    @(negedge sys_clk_i);
    n++;
    chk({8'h00, w_o}, {8'h00, ew});
    chk({8'h00, status_o}, {8'h00, es});
    if (en > 0) chk(16'(n), 16'(en));
  endtask : step_check

  //////////////////////////////////////////////////////////////////////////
  // Literal adds: carry out of bit 7 and bit 3, zero result
  task t_add;
    step_check(8'h00, 8'h00, 20);
    step_check(8'h3c, 8'h00, 20);
    step_check(8'h00, 8'h07, 20);
    step_check(8'h05, 8'h00, 20);
  endtask : t_add

  // Store W to a file register while fetching goes on
  task t_store;
    step_check(8'h05, 8'h00, 20);
    chk({8'h00, mem_u.data[8'h20]}, 16'h0005);
  endtask : t_store

  // Register minus W without then with borrow
  task t_sub;
    step_check(8'hfa, 8'h03, 20);
    step_check(8'h09, 8'h00, 20);
  endtask : t_sub

  // Jump drops the prefetched word and costs a second cycle
  task t_branch;
    step_check(8'h09, 8'h00, 20);
    step_check(8'h09, 8'h00, 20);
    chk({3'b000, pmem_addr}, 16'h0009);
    step_check(8'h89, 8'h00, 20);
  endtask : t_branch

  // Program counter low byte and status read through data space
  task t_sfr;
    step_check(8'h0a, 8'h00, 20);
    step_check(8'h00, 8'h04, 20);
    chk(16'(mem_u.n_writes), 16'h0001);
  endtask : t_sfr

  // Pointer loaded from W, then a rotate reads through address 0
  task t_indirect;
    step_check(8'h22, 8'h00, 20);
    step_check(8'h22, 8'h00, 20);
    chk(16'(mem_u.n_writes), 16'h0001);
    step_check(8'hfe, 8'h01, 20);
  endtask : t_indirect

  // Writing the low counter byte redirects the fetch like a jump
  task t_pcl;
    step_check(8'h11, 8'h01, 20);
    step_check(8'h11, 8'h01, 20);
    step_check(8'h11, 8'h01, 20);
    chk({3'b000, pmem_addr}, 16'h0012);
  endtask : t_pcl

  // Literal AND, then single-operand forms on W and on a file register
  task t_unary;
    step_check(8'h01, 8'h01, 20);
    step_check(8'h01, 8'h01, 20);
    chk({8'h00, mem_u.data[8'h21]}, 16'h0002);
    step_check(8'h02, 8'h01, 20);
    step_check(8'h81, 8'h00, 20);
    step_check(8'h18, 8'h00, 20);
    step_check(8'he7, 8'h00, 20);
    step_check(8'h00, 8'h04, 20);
  endtask : t_unary

  //////////////////////////////////////////////////////////////////////////
  // Program image: words 7 and 16 are traps that must never execute
  initial begin
    mem_u.prog = '{14'h013c, 14'h01c4, 14'h0105, 14'h3220,
                   14'h0422, 14'h0421, 14'h3c08, 14'h0155,
                   14'h0d80, 14'h1402, 14'h1403, 14'h0d22,
                   14'h3204, 14'h2400, 14'h11ef, 14'h3202,
                   14'h0155, 14'h090f, 14'h2221, 14'h1d00,
                   14'h2900, 14'h3500, 14'h1900, 14'h2d00,
                   14'h3800, 14'h3800, 14'h3800, 14'h3800,
                   14'h3800, 14'h3800, 14'h3800, 14'h3800};
    @(negedge sys_clk_i);
    mem_u.data[8'h21] = 8'h03;
    mem_u.data[8'h22] = 8'hff;
    do_reset();
    t_add();
    t_store();
    t_sub();
    t_branch();
    t_sfr();
    t_indirect();
    t_pcl();
    t_unary();
    // A second reset in mid-run brings the core back to its start
    do_reset();
    step_check(8'h00, 8'h00, 20);
    step_check(8'h3c, 8'h00, 20);
    complete_run();
  end
endmodule : harvard_core_alu_datapath_tb

/* hcad_alu.sv */
// Eight-bit arithmetic and logic unit with carry and nibble carry
`timescale 1ns/100ps
module hcad_alu import hcad_pkg::*; (
  // Clock and reset, used only by the checks
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Operation and operands
  input  hcad_op_t               op_i,
  input  wire logic [DATA_W-1:0] a_i,
  input  wire logic [DATA_W-1:0] b_i,
  input  wire logic              c_i,
  // Result and flags
  output logic      [DATA_W-1:0] y_o,
  output logic                   c_o,
  output logic                   dc_o,
  output logic                   z_o
);

  logic [DATA_W:0] sum9;
  logic [DATA_W:0] dif9;
  logic [4:0]      nsum;
  logic [4:0]      ndif;

  // Wide sums expose carry and borrow out of bit 7 and bit 3
  assign sum9 = {1'b0, a_i} + {1'b0, b_i};
  assign dif9 = {1'b0, b_i} - {1'b0, a_i};
  assign nsum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
  assign ndif = {1'b0, b_i[3:0]} - {1'b0, a_i[3:0]};

  //////////////////////////////////////////////////////////////////////////
  // Operation select
  always_comb begin
    y_o  = b_i;
    c_o  = c_i;
    dc_o = 1'b0;
    case (op_i)
      OP_ADD: begin
        y_o  = sum9[DATA_W-1:0];
        c_o  = sum9[DATA_W];
        dc_o = nsum[4];
      end
      OP_SUB: begin
        y_o  = dif9[DATA_W-1:0];
        c_o  = ~dif9[DATA_W];
        dc_o = ~ndif[4];
      end
      OP_AND: y_o = a_i & b_i;
      OP_IOR: y_o = a_i | b_i;
      OP_XOR: y_o = a_i ^ b_i;
      OP_COM: y_o = ~b_i;
      OP_INC: y_o = b_i + 8'h01;
      OP_DEC: y_o = b_i - 8'h01;
      OP_RLF: begin
        y_o = {b_i[DATA_W-2:0], c_i};
        c_o = b_i[DATA_W-1];
      end
      OP_RRF: begin
        y_o = {c_i, b_i[DATA_W-1:1]};
        c_o = b_i[0];
      end
      OP_CLR: y_o = 8'h00;
      OP_STW: y_o = a_i;
      OP_SWP: y_o = {b_i[3:0], b_i[7:4]};
      default: y_o = b_i;
    endcase
  end

  assign z_o = (y_o == 8'h00);

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sub_c;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    op_i == OP_SUB |-> c_o == (b_i >= a_i);
  endproperty
  a_sub_c: assert property (p_sub_c)
    else $error("Subtract carry is not the inverted borrow");

  property p_sub_dc;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    op_i == OP_SUB |-> dc_o == (b_i[3:0] >= a_i[3:0]);
  endproperty
  a_sub_dc: assert property (p_sub_dc)
    else $error("Subtract nibble carry is not the inverted borrow");

  property p_add_dc;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    op_i == OP_ADD |-> dc_o == ((5'(a_i[3:0]) + 5'(b_i[3:0])) > 5'h0f);
  endproperty
  a_add_dc: assert property (p_add_dc)
    else $error("Add nibble carry does not follow bit 3 carry");

  property p_add_y;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    op_i == OP_ADD |-> y_o == 8'(a_i + b_i) && c_o == (9'(a_i) + 9'(b_i) > 9'h0ff);
  endproperty
  a_add_y: assert property (p_add_y)
    else $error("Add result or carry wrong");

endmodule : hcad_alu

/* hcad_core.sv */
// Harvard core datapath: fetch/execute pipeline, W, status and SFRs
//
// What this block does
// - Fetch and data access run on separate ports at the same time.
// - Each 14-bit instruction word is fetched whole in one cycle.
// - Fetch of the next word overlaps execution of the current one.
// - Non-branch instructions finish in one 200 ns instruction cycle.
// - Program counter spans up to 8K words; no external program memory.
// - Core registers, program counter low byte included, sit in data space.
// - Every ALU operation works on any data register by any address mode.
// - The 8-bit ALU adds, subtracts, shifts and does logic operations.
// - Arithmetic treats operands and results as two's complement.
// - Two-operand forms use W with a data register or a literal.
// - Single-operand forms use either W or a data register.
// - W is an 8-bit accumulator with no data-space address.
// - ALU updates carry, nibble carry and zero per instruction.
// - In subtraction carry and nibble carry report inverted borrows.
`timescale 1ns/100ps
module hcad_core import hcad_pkg::*; (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  // Program memory fetch port
  output logic      [PC_W-1:0]    pmem_addr_o,
  input  wire logic [INSTR_W-1:0] pmem_data_i,
  // Data register file port
  output logic      [FADDR_W-1:0] dmem_addr_o,
  input  wire logic [DATA_W-1:0]  dmem_rdata_i,
  output logic      [DATA_W-1:0]  dmem_wdata_o,
  output logic                    dmem_we_o,
  // Observation
  output logic      [DATA_W-1:0]  w_o,
  output logic      [DATA_W-1:0]  status_o,
  output logic                    icyc_o
);

  logic [CNT_W-1:0]   cnt;
  logic               ce;
  logic [PC_W-1:0]    pc;
  logic [INSTR_W-1:0] ir;
  logic [DATA_W-1:0]  w;
  logic [DATA_W-1:0]  status;
  logic [DATA_W-1:0]  fsr;
  hcad_op_t           op;
  logic               is_jmp;
  logic               is_nop;
  logic               src_k;
  logic               single;
  logic               dest_f;
  logic [FADDR_W-1:0] faddr;
  logic [FADDR_W-1:0] ea;
  logic [DATA_W-1:0]  file_val;
  logic [DATA_W-1:0]  b_opnd;
  logic [DATA_W-1:0]  alu_y;
  logic               alu_c;
  logic               alu_dc;
  logic               alu_z;
  logic               aff_c;
  logic               aff_dc;
  logic               aff_z;
  logic               wr_core;
  logic               ext_wr;
  logic               branch;
  logic [PC_W-1:0]    br_target;
  logic [DATA_W-1:0]  next_status;

  //////////////////////////////////////////////////////////////////////////
  // Instruction cycle divider: one enable pulse every 200 ns
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

  assign ce = (cnt == CYC_LAST);

  //////////////////////////////////////////////////////////////////////////
  // Decode of the word under execution
  assign op     = hcad_op_t'(ir[OP_HI:OP_LO]);
  assign is_jmp = (op == OP_JMP);
  assign is_nop = (op == OP_NOP);
  assign src_k  = ir[SRC_BIT];
  assign faddr  = ir[FADDR_W-1:0];
  assign single = (op inside {OP_MOV, OP_COM, OP_INC, OP_DEC, OP_RLF,
                              OP_RRF, OP_CLR, OP_STW, OP_SWP});
  // A literal has nowhere to go but W, so the file destination needs a
  // register operand
  assign dest_f = ir[DEST_BIT] & ~src_k & ~is_jmp & ~is_nop;

  // Address 0 reads through the pointer register for indirect access
  assign ea = (faddr == ADDR_INDF) ? fsr : faddr;

  // Core registers answer from inside; the rest comes from the file
  always_comb begin
    case (ea)
      ADDR_PCL:    file_val = pc[DATA_W-1:0];
      ADDR_STATUS: file_val = status;
      ADDR_FSR:    file_val = fsr;
      default:     file_val = dmem_rdata_i;
    endcase
  end

  // Second operand: register, literal, or W for single-operand forms
  always_comb begin
    if (!src_k) begin
      b_opnd = file_val;
    end else if (single) begin
      b_opnd = w;
    end else begin
      b_opnd = faddr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Arithmetic unit, W is always the first operand
  hcad_alu u_alu (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .op_i      (op),
    .a_i       (w),
    .b_i       (b_opnd),
    .c_i       (status[STATUS_C]),
    .y_o       (alu_y),
    .c_o       (alu_c),
    .dc_o      (alu_dc),
    .z_o       (alu_z)
  );

  //////////////////////////////////////////////////////////////////////////
  // Flag update and destination decode
  assign aff_c  = (op inside {OP_ADD, OP_SUB, OP_RLF, OP_RRF});
  assign aff_dc = (op inside {OP_ADD, OP_SUB});
  assign aff_z  = (op inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
                              OP_MOV, OP_COM, OP_INC, OP_DEC, OP_CLR});
  assign wr_core = (ea inside {ADDR_PCL, ADDR_STATUS, ADDR_FSR});
  assign ext_wr  = dest_f & ~wr_core;

  // Flags win over a plain write of the status register
  always_comb begin
    next_status = (dest_f && ea == ADDR_STATUS) ? alu_y : status;
    if (aff_c) begin
      next_status[STATUS_C] = alu_c;
    end
    if (aff_dc) begin
      next_status[STATUS_DC] = alu_dc;
    end
    if (aff_z) begin
      next_status[STATUS_Z] = alu_z;
    end
  end

  // A jump or a write to the low counter byte redirects the fetch
  assign branch    = is_jmp | (dest_f & (ea == ADDR_PCL));
  assign br_target = is_jmp ? {pc[PC_W-1:JMP_W], ir[JMP_W-1:0]}
                            : {pc[PC_W-1:DATA_W], alu_y};

  //////////////////////////////////////////////////////////////////////////
  // Fetch stage: the counter always points at the word being prefetched
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pc <= RST_PC;
    end else if (ce) begin
      if (branch) begin
        pc <= br_target;
      end else begin
        pc <= pc + 13'h0001;
      end
    end
  end

  // Prefetched word moves to execute; a branch throws it away
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ir <= NOP_WORD;
    end else if (ce) begin
      if (branch) begin
        ir <= NOP_WORD;
      end else begin
        ir <= pmem_data_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Working register, reachable only through the ALU
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      w <= RST_W;
    end else if (ce && !dest_f && !is_jmp && !is_nop) begin
      w <= alu_y;
    end
  end

  // Status register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      status <= RST_STATUS;
    end else if (ce) begin
      status <= next_status;
    end
  end

  // Indirect pointer
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      fsr <= RST_FSR;
    end else if (ce && dest_f && ea == ADDR_FSR) begin
      fsr <= alu_y;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data port: address follows the executing word while the program port
  // fetches the next, so both memories work in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      dmem_addr_o  <= '0;
      dmem_wdata_o <= '0;
      dmem_we_o    <= 1'b0;
      icyc_o       <= 1'b0;
    end else begin
      dmem_addr_o  <= ea;
      dmem_we_o    <= (cnt == CYC_PRE) && ext_wr;
      icyc_o       <= (cnt == CYC_PRE);
      if (cnt == CYC_PRE) begin
        dmem_wdata_o <= alu_y;
      end
    end
  end

  assign pmem_addr_o = pc;
  assign w_o         = w;
  assign status_o    = status;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cycle_len;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ce |=> (!ce)[*8] ##1 (!ce)[*8] ##1 (!ce)[*3] ##1 ce;
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("Instruction cycle is not 20 clocks");

  property p_fetch;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ce && !branch |=> ir == $past(pmem_data_i) && pc == $past(pc) + 13'h0001;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("Prefetched word not moved to execute");

  sequence s_branch;
    ce && branch;
  endsequence
  sequence s_flushed;
    ir == NOP_WORD && pmem_addr_o == $past(br_target);
  endsequence
  property p_branch;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_branch |=> s_flushed ##19 (ce && !branch);
  endproperty
  a_branch: assert property (p_branch)
    else $error("Branch did not flush and refetch");

  property p_w_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !ce |=> $stable(w) && $stable(status);
  endproperty
  a_w_hold: assert property (p_w_hold)
    else $error("W or status changed inside a cycle");

  property p_indirect;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    cnt == CYC_ADDR |-> dmem_addr_o == ((faddr == ADDR_INDF) ? fsr : faddr);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("Data address does not follow the mode");

  property p_zero;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ce && aff_z |=> status[STATUS_Z] == ($past(alu_y) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("Zero flag does not match result");

  property p_w_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ce && src_k && !single && !is_jmp && !is_nop |=> w == $past(alu_y);
  endproperty
  a_w_write: assert property (p_w_write)
    else $error("Literal result did not reach W");

endmodule : hcad_core

/* hcad_mem_model.sv */
// Program store and data file model facing the core's two memory ports
`timescale 1ns/100ps
module hcad_mem_model import hcad_pkg::*; (
  // Clock
  input  wire logic               sys_clk_i,
  // Program fetch port
  input  wire logic [PC_W-1:0]    pmem_addr_i,
  output logic      [INSTR_W-1:0] pmem_data_o,
  // Data file port
  input  wire logic [FADDR_W-1:0] dmem_addr_i,
  output logic      [DATA_W-1:0]  dmem_rdata_o,
  input  wire logic [DATA_W-1:0]  dmem_wdata_i,
  input  wire logic               dmem_we_i
);
  logic [INSTR_W-1:0] prog [32];
  logic [DATA_W-1:0]  data [256];
  int                 n_writes;

  //////////////////////////////////////////////////////////////////////////
  // Data file starts cleared; the bench loads its operands later
  initial begin
    n_writes = 0;
    foreach (data[i]) data[i] = 8'h00;
  end

  // Whole 14-bit word per address; past the loaded part only no-ops
  assign pmem_data_o = (pmem_addr_i < 32) ? prog[pmem_addr_i[4:0]]
                                          : NOP_WORD;

  // Separate data port read, independent of the fetch port
  assign dmem_rdata_o = data[dmem_addr_i];

  // Store on the edge that ends the write strobe
  always @(posedge sys_clk_i) begin
    if (dmem_we_i === 1'b1) begin
      data[dmem_addr_i] <= dmem_wdata_i;
      n_writes++;
    end
  end
endmodule : hcad_mem_model

/* hcad_pkg.sv */
// Shared constants and types for the Harvard core datapath
package hcad_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PC_W    = 13;     // Covers the largest 8K-word program store
  localparam int INSTR_W = 14;     // Instruction word width
  localparam int DATA_W  = 8;      // Data path and accumulator width
  localparam int FADDR_W = 8;      // Data-space address width
  localparam int JMP_W   = 10;     // Jump target field inside a word
  localparam int CNT_W   = 5;      // Width of the instruction cycle divider

  //////////////////////////////////////////////////////////////////////////
  // Timing: one instruction cycle of 200 ns on a 10 ns system clock
  localparam int CLK_PERIOD_NS  = 10;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int CYC_PER_INSTR  = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYC_PER_INSTR - 1);
  localparam logic [CNT_W-1:0] CYC_PRE  = CNT_W'(CYC_PER_INSTR - 2);
  localparam logic [CNT_W-1:0] CYC_ADDR = CNT_W'(2);

  //////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int OP_HI    = 13;
  localparam int OP_LO    = 10;
  localparam int DEST_BIT = 9;     // 1: result to data space, 0: to W
  localparam int SRC_BIT  = 8;     // 1: literal (two-op) or W (single-op)

  //////////////////////////////////////////////////////////////////////////
  // Core registers mapped into the data space
  localparam logic [FADDR_W-1:0] ADDR_INDF   = 8'h00;
  localparam logic [FADDR_W-1:0] ADDR_PCL    = 8'h02;
  localparam logic [FADDR_W-1:0] ADDR_STATUS = 8'h03;
  localparam logic [FADDR_W-1:0] ADDR_FSR    = 8'h04;

  // Status register bit positions
  localparam int STATUS_C  = 0;
  localparam int STATUS_DC = 1;
  localparam int STATUS_Z  = 2;

  //////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PC_W-1:0]    RST_PC     = 13'h0000;
  localparam logic [DATA_W-1:0]  RST_W      = 8'h00;
  localparam logic [DATA_W-1:0]  RST_STATUS = 8'h00;
  localparam logic [DATA_W-1:0]  RST_FSR    = 8'h00;
  localparam logic [INSTR_W-1:0] NOP_WORD   = 14'h3800;

  //////////////////////////////////////////////////////////////////////////
  // Operation codes
  typedef enum logic [3:0] {
    OP_ADD = 4'b0000,
    OP_SUB = 4'b0001,
    OP_AND = 4'b0010,
    OP_IOR = 4'b0011,
    OP_XOR = 4'b0100,
    OP_MOV = 4'b0101,
    OP_COM = 4'b0110,
    OP_INC = 4'b0111,
    OP_DEC = 4'b1000,
    OP_RLF = 4'b1001,
    OP_RRF = 4'b1010,
    OP_CLR = 4'b1011,
    OP_STW = 4'b1100,
    OP_SWP = 4'b1101,
    OP_NOP = 4'b1110,
    OP_JMP = 4'b1111
  } hcad_op_t;

endpackage : hcad_pkg
